// ===== pl_pkg.sv
// package: constants, enums and helpers of the party-line bus interface
// Overview of operation
// - Up to 64 devices share the bus, each picked by a six-bit address.
// - Shared bus is 16 lines wide, or 18 in the wide build.
// - Bus lines carry control codes, device addresses or data, per operation.
// - Function-ready is high only while a valid function word is driven.
// - Data-ready is high only while a valid data word is on the bus.
// - Processor broadcasts a continuous 1.1 MHz interrupt clock.
// - Processor drives priority into the chain; modules resolve grants from it.
// - Console interrupt taken only when the chain returns unclaimed.
// - Intermediate priority lines 2 and 3 are wiring only, along the bus.
// - Processor drives the system-reset party line from console reset.
// - Trap suspends the program without changing sequence, then resumes.
// - Program ops: control code, sense, register transfer, memory transfer.
// - Priority is re-evaluated every 1.8 us, locked to the interrupt clock.
// - Each trapped transfer holds the program for 2.7 us.
// - Function word: operation in upper bits, device 00 to 63 in low six.
package pl_pkg;
  localparam int CLK_PERIOD_NS    = 10;
  localparam int CLK_KHZ          = 100000;
  localparam int IRQ_CLK_KHZ      = 1100;
  localparam int IRQ_CLK_HALF_CYC = CLK_KHZ / (2 * IRQ_CLK_KHZ);
  localparam int PRIO_NS          = 1800;
  localparam int PRIO_IRQ_PERIODS = (PRIO_NS * IRQ_CLK_KHZ + 500000) / 1000000;
  localparam int TRAP_NS          = 2700;
  localparam int TRAP_CYC         = (TRAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_TURN_CYC     = 2;
  localparam int BUS_STROBE_CYC   = 4;
  localparam int EBUS_W_BASE      = 16;
  localparam int EBUS_W_WIDE      = 18;
  localparam int MAX_DEVICES      = 64;
  localparam int DEV_W            = 6;
  localparam int FN_CODE_W        = 3;
  localparam int FN_DEV_LSB       = 0;
  localparam int FN_CODE_LSB      = 6;
  localparam int FN_CTRL_BIT      = 11;
  localparam int FN_SENSE_BIT     = 12;
  localparam int FN_DIN_BIT       = 13;
  localparam int FN_DOUT_BIT      = 14;
  localparam int FN_AUX_BIT       = 15;
  localparam logic SYSRST_RESET   = 1'b1;

  typedef enum logic [2:0] {
    PL_OP_DOUT  = 3'h0,
    PL_OP_DIN   = 3'h1,
    PL_OP_SENSE = 3'h2,
    PL_OP_CTRL  = 3'h3,
    PL_OP_AUX   = 3'h4
  } pl_op_e;

  typedef enum logic [2:0] {
    PL_JOB_FUNC   = 3'h0,
    PL_JOB_DOUT   = 3'h1,
    PL_JOB_DIN    = 3'h2,
    PL_JOB_SENSE  = 3'h3,
    PL_JOB_IRQ    = 3'h4,
    PL_JOB_SAMPLE = 3'h5
  } pl_job_e;

  function automatic logic pl_job_drives(input pl_job_e k);
    pl_job_drives = (k == PL_JOB_FUNC) || (k == PL_JOB_DOUT) || (k == PL_JOB_SENSE);
  endfunction : pl_job_drives

  function automatic logic [EBUS_W_WIDE-1:0] pl_fn_word(input pl_op_e op,
                                                        input logic [FN_CODE_W-1:0] fc,
                                                        input logic [DEV_W-1:0] dev);
    logic [EBUS_W_WIDE-1:0] w;
    w = '0;
    w[FN_DEV_LSB +: DEV_W] = dev;
    w[FN_CODE_LSB +: FN_CODE_W] = fc;
    case (op)
      PL_OP_DOUT:  w[FN_DOUT_BIT]  = 1'b1;
      PL_OP_DIN:   w[FN_DIN_BIT]   = 1'b1;
      PL_OP_SENSE: w[FN_SENSE_BIT] = 1'b1;
      PL_OP_CTRL:  w[FN_CTRL_BIT]  = 1'b1;
      default:     w[FN_AUX_BIT]   = 1'b1;
    endcase
    pl_fn_word = w;
  endfunction : pl_fn_word
endpackage : pl_pkg

// ===== pl_xfer_if.sv
// interface: one word handed from a source to a clock-crossing sink
`timescale 1ns/1ps
`default_nettype none
interface pl_xfer_if #(parameter int W = 8) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface : pl_xfer_if
`default_nettype wire

// ===== pl_tick.sv
// module: interrupt clock divider and priority evaluation strobe
`timescale 1ns/1ps
`default_nettype none
module pl_tick
  import pl_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  output logic      irq_clock,
  output logic      prio_tick
);
  localparam logic [6:0] HALF_LAST = 7'(IRQ_CLK_HALF_CYC - 1);
  localparam logic [1:0] PER_LAST  = 2'(PRIO_IRQ_PERIODS - 1);

  typedef struct packed {
    logic [6:0] cnt;
    logic       lvl;
    logic [1:0] per;
    logic       tick;
  } pl_tick_s;

  pl_tick_s s;
  pl_tick_s next_s;

  always_comb
  begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt == HALF_LAST)
    begin
      next_s.cnt = '0;
      next_s.lvl = ~s.lvl;
      if (!s.lvl)
      begin
        // strobe rides the rising edge so arbitration is locked to the clock
        if (s.per == PER_LAST)
        begin
          next_s.per  = '0;
          next_s.tick = 1'b1;
        end
        else
        begin
          next_s.per = s.per + 2'h1;
        end
      end
    end
    else
    begin
      next_s.cnt = s.cnt + 7'h01;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign irq_clock = s.lvl;
  assign prio_tick = s.tick;
endmodule : pl_tick
`default_nettype wire

// ===== pl_cdc_word.sv
// module: toggle-handshake crossing of one word between two clocks
`timescale 1ns/1ps
`default_nettype none
module pl_cdc_word #(
  parameter int W = 8
) (
  input  wire logic         src_clk,
  input  wire logic         src_rst,
  input  wire logic         dst_clk,
  input  wire logic         dst_rst,
  pl_xfer_if.sink           src,
  output logic              dst_valid,
  output logic [W-1:0]      dst_data
);
  typedef struct packed {
    logic         req;
    logic [1:0]   ack_s;
    logic [W-1:0] hold;
  } pl_cdc_src_s;

  typedef struct packed {
    logic [2:0]   req_s;
    logic         ack;
    logic         valid;
    logic [W-1:0] data;
  } pl_cdc_dst_s;

  pl_cdc_src_s s;
  pl_cdc_src_s next_s;
  pl_cdc_dst_s d;
  pl_cdc_dst_s next_d;

  assign src.ready = (s.req == s.ack_s[1]);

  always_comb
  begin
    next_s = s;
    next_s.ack_s = {s.ack_s[0], d.ack};
    if (src.valid && src.ready)
    begin
      next_s.req  = ~s.req;
      next_s.hold = src.data;
    end
  end

  // hold is stable from the toggle until the ack returns, so it is safe to copy
  always_comb
  begin
    next_d = d;
    next_d.req_s = {d.req_s[1:0], s.req};
    next_d.valid = (d.req_s[2] != d.req_s[1]);
    if (d.req_s[2] != d.req_s[1])
      next_d.data = s.hold;
    next_d.ack = d.req_s[2];
  end

  always_ff @(posedge src_clk or posedge src_rst)
  begin
    if (src_rst)
      s <= '0;
    else
      s <= next_s;
  end

  always_ff @(posedge dst_clk or posedge dst_rst)
  begin
    if (dst_rst)
      d <= '0;
    else
      d <= next_d;
  end

  assign dst_valid = d.valid;
  assign dst_data  = d.data;
endmodule : pl_cdc_word
`default_nettype wire

// ===== pl_bus_ctrl.sv
// module: processor end of the party-line bus, core side and priority, reset and request lines on clk, bus word and strobes on bus_clk
`timescale 1ns/1ps
`default_nettype none
module pl_bus_ctrl
  import pl_pkg::*;
#(
  parameter int W = EBUS_W_BASE
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             bus_clk,
  input  wire logic             cmd_valid,
  output logic                  cmd_ready,
  input  wire pl_op_e           cmd_op,
  input  wire logic [DEV_W-1:0] cmd_dev,
  input  wire logic [FN_CODE_W-1:0] cmd_func,
  input  wire logic [W-1:0]     cmd_wdata,
  output logic                  rsp_valid,
  output logic [W-1:0]          rsp_rdata,
  output logic                  rsp_sense,
  output logic                  mem_req,
  output logic                  mem_we,
  output logic [W-1:0]          mem_addr,
  output logic [W-1:0]          mem_wdata,
  input  wire logic [W-1:0]     mem_rdata,
  input  wire logic             mem_ack,
  output logic                  program_hold,
  output logic                  irq_valid,
  output logic [W-1:0]          irq_vector,
  output logic                  irq_jump,
  input  wire logic             console_irq,
  output logic                  console_grant,
  input  wire logic             console_reset,
  input  wire logic [W-1:0]     ebus_in,
  output logic [W-1:0]          ebus_out,
  output logic                  ebus_oe_n,
  output logic                  function_ready,
  output logic                  data_ready_strobe,
  input  wire logic             sense_reply,
  input  wire logic             irq_demand,
  output logic                  irq_ack,
  input  wire logic             irq_jump_flag,
  input  wire logic             trap_read_request,
  input  wire logic             trap_write_request,
  output logic                  irq_clock,
  output logic                  priority_chain_out,
  input  wire logic             priority_chain_return,
  output logic                  system_reset_line
);
  localparam int HC_W = $clog2(TRAP_CYC + 1);
  localparam logic [HC_W-1:0] TRAP_LAST   = HC_W'(TRAP_CYC - 1);
  localparam logic [2:0]      TURN_LAST   = 3'(BUS_TURN_CYC - 1);
  localparam logic [2:0]      STROBE_LAST = 3'(BUS_STROBE_CYC - 1);
  localparam int JW = W + 3;
  localparam int RW = W + 2;

  typedef enum logic [2:0] {
    PL_C_IDLE = 3'h0,
    PL_C_JOB  = 3'h1,
    PL_C_WAIT = 3'h2,
    PL_C_MEM  = 3'h3,
    PL_C_HOLD = 3'h4
  } pl_cst_e;

  typedef enum logic [2:0] {
    PL_A_DOUT  = 3'h0,
    PL_A_DIN   = 3'h1,
    PL_A_SENSE = 3'h2,
    PL_A_CTRL  = 3'h3,
    PL_A_TRD   = 3'h4,
    PL_A_TWR   = 3'h5,
    PL_A_IRQ   = 3'h6
  } pl_act_e;

  typedef enum logic [1:0] {
    PL_B_IDLE   = 2'h0,
    PL_B_TURN   = 2'h1,
    PL_B_STROBE = 2'h2,
    PL_B_DONE   = 2'h3
  } pl_bst_e;

  typedef struct packed {
    logic [5:0]      s1;
    logic [5:0]      s2;
    pl_cst_e         state;
    pl_act_e         act;
    logic            step;
    logic            job_valid;
    pl_job_e         job_kind;
    logic [W-1:0]    job_word;
    logic [W-1:0]    addr;
    logic [W-1:0]    wdata;
    logic            mem_req;
    logic            mem_we;
    logic            hold;
    logic [HC_W-1:0] hold_cnt;
    logic            rsp_valid;
    logic [W-1:0]    rsp_rdata;
    logic            rsp_sense;
    logic            irq_valid;
    logic [W-1:0]    irq_vector;
    logic            irq_jump;
    logic            con_grant;
    logic            sysrst;
    logic            prio_open;
  } pl_clk_s;

  typedef struct packed {
    logic [RW-1:0] s1;
    logic [RW-1:0] s2;
    pl_bst_e       state;
    pl_job_e       kind;
    logic [W-1:0]  word;
    logic [2:0]    cnt;
    logic [W-1:0]  ebus_out;
    logic          oe_n;
    logic          fr;
    logic          dr;
    logic          ack;
    logic          res_valid;
    logic [RW-1:0] res_data;
  } pl_bus_s;

  pl_clk_s c;
  pl_clk_s next_c;
  pl_bus_s b;
  pl_bus_s next_b;
  logic [1:0] brst_s;
  logic       bus_rst;
  logic       prio_tick;
  logic       job_dst_valid;
  logic [JW-1:0] job_dst_data;
  logic       res_dst_valid;
  logic [RW-1:0] res_dst_data;
  logic       trd;
  logic       twr;
  logic       irq_req;
  logic       chain_free;
  logic       con_req;
  logic       auto_take;

  pl_xfer_if #(.W(JW)) job_if ();
  pl_xfer_if #(.W(RW)) res_if ();

  pl_tick u_tick (
    .clk       (clk),
    .rst       (rst),
    .irq_clock (irq_clock),
    .prio_tick (prio_tick)
  );

  pl_cdc_word #(.W(JW)) u_job_cdc (
    .src_clk   (clk),
    .src_rst   (rst),
    .dst_clk   (bus_clk),
    .dst_rst   (bus_rst),
    .src       (job_if.sink),
    .dst_valid (job_dst_valid),
    .dst_data  (job_dst_data)
  );

  pl_cdc_word #(.W(RW)) u_res_cdc (
    .src_clk   (bus_clk),
    .src_rst   (bus_rst),
    .dst_clk   (clk),
    .dst_rst   (rst),
    .src       (res_if.sink),
    .dst_valid (res_dst_valid),
    .dst_data  (res_dst_data)
  );

  function automatic pl_clk_s send_job(input pl_clk_s x, input pl_job_e k,
                                       input logic [W-1:0] w);
    pl_clk_s y;
    y = x;
    y.job_valid = 1'b1;
    y.job_kind  = k;
    y.job_word  = w;
    y.state     = PL_C_JOB;
    send_job = y;
  endfunction : send_job

  assign trd        = c.s2[0];
  assign twr        = c.s2[1];
  assign irq_req    = c.s2[2];
  assign chain_free = c.s2[3];
  assign con_req    = c.s2[4];
  // program commands yield to any service that wins this priority slot
  assign auto_take  = prio_tick && (trd || twr || irq_req || (con_req && chain_free));
  assign cmd_ready  = (c.state == PL_C_IDLE) && !auto_take;
  assign job_if.valid = c.job_valid;
  assign job_if.data  = {c.job_kind, c.job_word};

  always_comb
  begin
    next_c = c;
    next_c.s1 = {console_reset, console_irq, priority_chain_return, irq_demand,
                 trap_write_request, trap_read_request};
    next_c.s2 = c.s1;
    next_c.rsp_valid = 1'b0;
    next_c.irq_valid = 1'b0;
    next_c.con_grant = 1'b0;
    next_c.sysrst = c.s2[5];
    if (c.hold && (c.hold_cnt != TRAP_LAST))
      next_c.hold_cnt = c.hold_cnt + HC_W'(1);
    if (c.job_valid && job_if.ready)
      next_c.job_valid = 1'b0;
    case (c.state)
      PL_C_IDLE:
      begin
        next_c.prio_open = 1'b1;
        next_c.step = 1'b0;
        if (prio_tick && (trd || twr))
        begin
          next_c.act = trd ? PL_A_TRD : PL_A_TWR;
          next_c.hold = 1'b1;
          next_c.hold_cnt = '0;
          next_c.prio_open = 1'b0;
          next_c = send_job(next_c, PL_JOB_SAMPLE, '0);
        end
        else if (prio_tick && irq_req)
        begin
          next_c.act = PL_A_IRQ;
          next_c.prio_open = 1'b0;
          next_c = send_job(next_c, PL_JOB_IRQ, '0);
        end
        else if (prio_tick && con_req && chain_free)
        begin
          next_c.con_grant = 1'b1;
        end
        else if (cmd_valid)
        begin
          next_c.wdata = cmd_wdata;
          case (cmd_op)
            PL_OP_DOUT:  next_c.act = PL_A_DOUT;
            PL_OP_DIN:   next_c.act = PL_A_DIN;
            PL_OP_SENSE: next_c.act = PL_A_SENSE;
            default:     next_c.act = PL_A_CTRL;
          endcase
          next_c = send_job(next_c, (cmd_op == PL_OP_SENSE) ? PL_JOB_SENSE : PL_JOB_FUNC,
                            W'(pl_fn_word(cmd_op, cmd_func, cmd_dev)));
        end
      end
      PL_C_JOB:
      begin
        if (c.job_valid && job_if.ready)
          next_c.state = PL_C_WAIT;
      end
      PL_C_WAIT:
      begin
        if (res_dst_valid)
        begin
          next_c.state = PL_C_IDLE;
          case (c.act)
            PL_A_DOUT, PL_A_DIN:
            begin
              if (!c.step)
              begin
                next_c.step = 1'b1;
                next_c = send_job(next_c, (c.act == PL_A_DOUT) ? PL_JOB_DOUT : PL_JOB_DIN,
                                  c.wdata);
              end
              else
              begin
                next_c.rsp_valid = 1'b1;
                next_c.rsp_rdata = res_dst_data[W-1:0];
              end
            end
            PL_A_SENSE, PL_A_CTRL:
            begin
              next_c.rsp_valid = 1'b1;
              next_c.rsp_sense = res_dst_data[W];
            end
            PL_A_TRD:
            begin
              if (!c.step)
              begin
                next_c.addr = res_dst_data[W-1:0];
                next_c.mem_req = 1'b1;
                next_c.mem_we = 1'b0;
                next_c.state = PL_C_MEM;
              end
              else
              begin
                next_c.state = PL_C_HOLD;
              end
            end
            PL_A_TWR:
            begin
              if (!c.step)
              begin
                next_c.addr = res_dst_data[W-1:0];
                next_c.step = 1'b1;
                next_c = send_job(next_c, PL_JOB_DIN, '0);
              end
              else
              begin
                next_c.wdata = res_dst_data[W-1:0];
                next_c.mem_req = 1'b1;
                next_c.mem_we = 1'b1;
                next_c.state = PL_C_MEM;
              end
            end
            default:
            begin
              next_c.irq_valid = 1'b1;
              next_c.irq_vector = res_dst_data[W-1:0];
              next_c.irq_jump = res_dst_data[W+1];
            end
          endcase
        end
      end
      PL_C_MEM:
      begin
        if (mem_ack)
        begin
          next_c.mem_req = 1'b0;
          if (c.act == PL_A_TRD)
          begin
            next_c.step = 1'b1;
            next_c = send_job(next_c, PL_JOB_DOUT, mem_rdata);
          end
          else
          begin
            next_c.state = PL_C_HOLD;
          end
        end
      end
      PL_C_HOLD:
      begin
        if (c.hold_cnt == TRAP_LAST)
        begin
          next_c.hold = 1'b0;
          next_c.state = PL_C_IDLE;
        end
      end
      default:
      begin
        next_c.state = PL_C_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      c <= '0;
      c.sysrst <= SYSRST_RESET;
    end
    else
    begin
      c <= next_c;
    end
  end

  // bus side holds its reset until two bus_clk edges after rst falls
  always_ff @(posedge bus_clk or posedge rst)
  begin
    if (rst)
      brst_s <= 2'b11;
    else
      brst_s <= {brst_s[0], 1'b0};
  end

  assign bus_rst = brst_s[1];
  assign res_if.valid = b.res_valid;
  assign res_if.data  = b.res_data;

  always_comb
  begin
    next_b = b;
    next_b.s1 = {irq_jump_flag, sense_reply, ebus_in};
    next_b.s2 = b.s1;
    if (b.res_valid && res_if.ready)
      next_b.res_valid = 1'b0;
    case (b.state)
      PL_B_IDLE:
      begin
        if (job_dst_valid)
        begin
          next_b.kind = pl_job_e'(job_dst_data[JW-1:W]);
          next_b.word = job_dst_data[W-1:0];
          next_b.cnt = '0;
          next_b.state = PL_B_TURN;
        end
      end
      PL_B_TURN:
      begin
        // released gap before every job, whichever way the next one drives
        next_b.cnt = b.cnt + 3'h1;
        if (b.cnt == TURN_LAST)
        begin
          next_b.cnt = '0;
          next_b.state = PL_B_STROBE;
          next_b.ebus_out = b.word;
          next_b.oe_n = !pl_job_drives(b.kind);
          next_b.fr = (b.kind == PL_JOB_FUNC) || (b.kind == PL_JOB_SENSE);
          next_b.dr = (b.kind == PL_JOB_DOUT) || (b.kind == PL_JOB_DIN);
          next_b.ack = (b.kind == PL_JOB_IRQ);
        end
      end
      PL_B_STROBE:
      begin
        next_b.cnt = b.cnt + 3'h1;
        if (b.cnt == STROBE_LAST)
        begin
          // sample on the last strobe cycle, after the two-stage settle
          next_b.res_data = b.s2;
          next_b.res_valid = 1'b1;
          next_b.oe_n = 1'b1;
          next_b.fr = 1'b0;
          next_b.dr = 1'b0;
          next_b.ack = 1'b0;
          next_b.state = PL_B_DONE;
        end
      end
      PL_B_DONE:
      begin
        if (!b.res_valid)
          next_b.state = PL_B_IDLE;
      end
      default:
      begin
        next_b.state = PL_B_IDLE;
      end
    endcase
  end

  always_ff @(posedge bus_clk or posedge bus_rst)
  begin
    if (bus_rst)
    begin
      b <= '0;
      b.oe_n <= 1'b1;
    end
    else
    begin
      b <= next_b;
    end
  end

  assign rsp_valid          = c.rsp_valid;
  assign rsp_rdata          = c.rsp_rdata;
  assign rsp_sense          = c.rsp_sense;
  assign mem_req            = c.mem_req;
  assign mem_we             = c.mem_we;
  assign mem_addr           = c.addr;
  assign mem_wdata          = c.wdata;
  assign program_hold       = c.hold;
  assign irq_valid          = c.irq_valid;
  assign irq_vector         = c.irq_vector;
  assign irq_jump           = c.irq_jump;
  assign console_grant      = c.con_grant;
  // mid chain lines pass device to device and never reach this end
  assign priority_chain_out = c.prio_open;
  assign system_reset_line  = c.sysrst;
  assign ebus_out           = b.ebus_out;
  assign ebus_oe_n          = b.oe_n;
  assign function_ready     = b.fr;
  assign data_ready_strobe  = b.dr;
  assign irq_ack            = b.ack;
endmodule : pl_bus_ctrl
`default_nettype wire

// ===== pl_bus_props.sv
// checker: timing relations at the bus controller ports
`timescale 1ns/1ps
`default_nettype none
module pl_bus_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_clk,
  input wire logic console_reset,
  input wire logic console_grant,
  input wire logic priority_chain_return,
  input wire logic rsp_valid,
  input wire logic program_hold,
  input wire logic irq_clock,
  input wire logic system_reset_line,
  input wire logic function_ready,
  input wire logic data_ready_strobe,
  input wire logic irq_ack,
  input wire logic ebus_oe_n
);
  AST_FR_LEN: assert property (@(posedge bus_clk) disable iff (rst)
    $rose(function_ready) |-> function_ready[*4] ##1 !function_ready) else $error("fr len");
  AST_FR_DRV: assert property (@(posedge bus_clk) disable iff (rst)
    function_ready |-> !ebus_oe_n && !irq_ack) else $error("fr not driven");
  AST_DRY_LEN: assert property (@(posedge bus_clk) disable iff (rst)
    $rose(data_ready_strobe) |-> data_ready_strobe[*4] ##1 !data_ready_strobe) else $error("dr");
  AST_ACK_REL: assert property (@(posedge bus_clk) disable iff (rst)
    irq_ack |-> ebus_oe_n) else $error("ack drives bus");
  AST_TURN: assert property (@(posedge bus_clk) disable iff (rst)
    $fell(ebus_oe_n) |-> $past(ebus_oe_n, 2)) else $error("no turn gap");
  AST_ICLK: assert property (@(posedge clk) disable iff (rst)
    $rose(irq_clock) |-> ##44 irq_clock ##1 !irq_clock) else $error("irq clock");
  AST_SYSRST: assert property (@(posedge clk) disable iff (rst)
    console_reset[*5] |-> system_reset_line) else $error("reset line");
  AST_GRANT: assert property (@(posedge clk) disable iff (rst)
    !priority_chain_return[*6] |-> !console_grant) else $error("grant claimed");
  AST_HOLD: assert property (@(posedge clk) disable iff (rst)
    $rose(program_hold) |-> ##269 program_hold) else $error("hold short");
  AST_RSP: assert property (@(posedge clk) disable iff (rst)
    rsp_valid |=> !rsp_valid) else $error("rsp long");
endmodule : pl_bus_props
bind pl_bus_ctrl pl_bus_props pl_bus_props_i (.*);
`default_nettype wire

// ===== pl_far_model.sv
// far side model: peripheral and interrupt module on the bus
`timescale 1ns/1ps
`default_nettype none
module pl_far_model (
  input  wire logic        bus_clk,
  input  wire logic [15:0] ebus_out,
  input  wire logic        ebus_oe_n,
  input  wire logic        function_ready,
  input  wire logic        data_ready_strobe,
  input  wire logic        irq_ack,
  input  wire logic        irq_want,
  input  wire logic [15:0] din_word,
  input  wire logic [15:0] vec,
  input  wire logic        trap_read_request,
  input  wire logic        trap_write_request,
  input  wire logic [15:0] trap_addr,
  output logic [15:0]      ebus_in,
  output logic             sense_reply,
  output logic             irq_demand = 1'b0,
  output logic             irq_jump_flag
);
  // released lines wander so a stale value never passes
  logic [15:0] idle = 16'h5a5a;
  always @(posedge bus_clk)
  begin
    idle <= ~idle;
    irq_demand <= irq_ack ? 1'b0 : (irq_demand | irq_want);
  end
  assign sense_reply = function_ready ? ~ebus_out[0] : idle[0];
  assign irq_jump_flag = irq_ack ? vec[0] : idle[1];
  // wire level: processor drive wins, else vector, else data word, else trap address, else idle
  assign ebus_in = !ebus_oe_n ? ebus_out : irq_ack ? vec
                 : data_ready_strobe ? din_word
                 : (trap_read_request | trap_write_request) ? trap_addr : idle;
endmodule : pl_far_model
`default_nettype wire

// ===== tb_top.sv
// bench: commands, interrupt, console and reset line
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pl_pkg::*;
;
  logic clk = 0, bus_clk = 0, rst = 1, cmd_valid = 0, mem_ack = 0, irq_want = 0;
  logic console_irq = 0, console_reset = 0, priority_chain_return = 1;
  logic trap_read_request = 0, trap_write_request = 0;
  pl_op_e cmd_op = PL_OP_DOUT;
  logic [5:0] cmd_dev = '0;
  logic [2:0] cmd_func = '0;
  logic [15:0] cmd_wdata = '0, mem_rdata = '0, din_word = '0, vec = '0, cap_fn, cap_dat;
  logic [15:0] rsp_rdata, mem_addr, mem_wdata, irq_vector, ebus_in, ebus_out, trap_addr;
  logic cmd_ready, rsp_valid, rsp_sense, mem_req, mem_we, program_hold, irq_valid, irq_jump;
  logic console_grant, ebus_oe_n, function_ready, data_ready_strobe, sense_reply, irq_ack;
  logic irq_demand, irq_jump_flag, irq_clock, priority_chain_out, system_reset_line;
  int mismatches = 0, n_tests = 0;
  always #5 clk = ~clk;
  initial #3.7 forever #16 bus_clk = ~bus_clk;
  pl_bus_ctrl pl_bus_ctrl_i (.*);
  pl_far_model pl_far_model_i (.*);
  always @(posedge clk) mem_ack <= mem_req & ~mem_ack;
  always @(posedge bus_clk)
  begin
    if (function_ready) cap_fn <= ebus_out;
    if (data_ready_strobe && !ebus_oe_n) cap_dat <= ebus_out;
  end
  task chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task stop_test;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // offered request held until cmd_ready is seen high at an edge
  task cmd(input pl_op_e op, input logic [5:0] d, input logic [2:0] f);
    int n;
    @(posedge clk) #1;
    cmd_op = op;
    {cmd_dev, cmd_func, cmd_wdata, cmd_valid} = {d, f, 16'hbeef, 1'b1};
    n = 0;
    @(negedge clk);
    while (cmd_ready !== 1'b1 && n++ < 400) @(negedge clk);
    @(posedge clk) #1 cmd_valid = 0;
    n = 0;
    while (rsp_valid !== 1'b1 && n++ < 500) @(negedge clk);
    chk(n < 500, "no response");
  endtask : cmd
  task t_ops;
    pl_op_e ops [5] = '{PL_OP_DOUT, PL_OP_DIN, PL_OP_SENSE, PL_OP_CTRL, PL_OP_AUX};
    int bits [5] = '{14, 13, 12, 11, 15};
    logic [15:0] e;
    logic [5:0] d;
    for (int i = 0; i < 5; i++)
    begin
      d = 6'(i * 13 + 11);
      e = '0;
      e[bits[i]] = 1'b1;
      e[8:6] = 3'(i + 3);
      e[5:0] = d;
      din_word = 16'h8421;
      cap_fn = 'x;
      cmd(ops[i], d, 3'(i + 3));
      chk(cap_fn === e, "function word");
      if (i == 0) chk(cap_dat === 16'hbeef, "data out");
      if (i == 1) chk(rsp_rdata === 16'h8421, "data in");
      if (i == 2) chk(rsp_sense === ~d[0], "sense");
    end
    $display("ops done");
  endtask : t_ops
  task t_irq;
    int n;
    for (int k = 0; k < 2; k++)
    begin
      vec = k ? 16'h3f40 : 16'h0a5b;
      irq_want = 1;
      repeat (3) @(posedge bus_clk) #1;
      irq_want = 0;
      n = 0;
      while (irq_valid !== 1'b1 && n++ < 600) @(negedge clk);
      chk(irq_vector === vec && irq_jump === vec[0], "vector");
    end
    $display("irq done");
  endtask : t_irq
  task t_trap;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk) #1;
      trap_addr = 16'h0123 + 16'(k);
      mem_rdata = 16'h6c3a;
      trap_read_request = (k == 0);
      trap_write_request = (k == 1);
      wait (program_hold === 1'b1);
      wait (program_hold === 1'b0);
      @(posedge clk) #1;
      {trap_read_request, trap_write_request} = 2'b00;
      chk(mem_addr === trap_addr && mem_we === (k == 1), "trap address");
      chk(k ? mem_wdata === din_word : cap_dat === mem_rdata, "trap data");
    end
    $display("trap done");
  endtask : t_trap
  task t_con;
    int n;
    @(posedge clk) #1 console_irq = 1;
    priority_chain_return = 0;
    n = 0;
    repeat (400) @(negedge clk) n += (console_grant === 1'b1);
    chk(n == 0, "grant while claimed");
    @(posedge clk) #1 priority_chain_return = 1;
    n = 0;
    while (console_grant !== 1'b1 && n++ < 400) @(negedge clk);
    chk(n < 400, "no grant");
    @(posedge clk) #1 console_irq = 0;
    chk(priority_chain_out === 1'b1, "chain idle");
    $display("console done");
  endtask : t_con
  task t_rst;
    realtime t0;
    @(posedge clk) #1 console_reset = 1;
    repeat (6) @(posedge clk) #1;
    chk(system_reset_line === 1'b1, "reset on");
    console_reset = 0;
    repeat (6) @(posedge clk) #1;
    chk(system_reset_line === 1'b0, "reset off");
    @(posedge irq_clock) t0 = $realtime;
    @(posedge irq_clock);
    chk($realtime - t0 == 2 * IRQ_CLK_HALF_CYC * CLK_PERIOD_NS, "irq clock");
    $display("reset done");
  endtask : t_rst
  initial
  begin
    repeat (8) @(posedge clk) #1;
    rst = 0;
    t_ops;
    t_irq;
    t_trap;
    t_con;
    t_rst;
    stop_test;
  end
  initial
  begin
    #300000;
    mismatches++;
    stop_test;
  end
endmodule : tb_top
`default_nettype wire
